// File: slc_stack_limit_checker.sv
// stack pointer, stack limit compare, stack error trap and secure ram gating
// assumes the cpu presents one stack request a cycle unless busy_out is high
`timescale 1ns/1ns
`include "slc_regs.svh"

module slc_stack_limit_checker
    import slc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        req_valid_in,
    input  wire slc_req_t    req_in,
    output logic             busy_out,
    input  wire logic        sp_wr_in,
    input  wire logic [15:0] sp_wdata_in,
    input  wire logic        limit_wr_in,
    input  wire logic [15:0] limit_wdata_in,
    input  wire slc_seg_t    boot_seg_in,
    input  wire slc_seg_t    secure_seg_in,
    input  wire logic        exec_boot_in,
    input  wire logic        exec_secure_in,
    input  wire logic        err_clr_in,
    output slc_mem_t         mem_out,
    output logic [15:0]      sp_out,
    output logic             stack_trap_out,
    output logic             stack_err_out,
    output logic             deny_out
);
    slc_state_t  state_q, state_d;
    logic [15:0] sp_q, sp_d;
    logic [15:0] hi_q, hi_d;
    slc_mem_t    mem_q, mem_d;
    logic        trap_q, trap_d;
    logic        err_q, err_d;
    logic        deny_q, deny_d;
    logic [15:0] lim_q, lim_d;
    logic        lim_set_q, lim_set_d;
    logic        take;
    logic        chk;
    logic        in_boot;
    logic        in_sec;
    logic [15:0] sp_dec;

    assign take   = req_valid_in && (state_q == SLC_IDLE) && (req_in.op != SLC_OP_NONE);
    assign sp_dec = 16'(sp_q - `SLC_WORD_STEP);                   // wraps on purpose

    // next state of pointer, access, trap and protection
    always_comb
    begin
        state_d = state_q;
        sp_d    = sp_q;
        hi_d    = hi_q;
        mem_d   = '0;
        chk     = 1'b0;
        if (state_q == SLC_PC_HI)
        begin
            mem_d = '{valid: 1'b1, write: 1'b1, addr: sp_q, wdata: hi_q};
            sp_d    = 16'(sp_q + `SLC_WORD_STEP);
            chk     = 1'b1;
            state_d = SLC_IDLE;
        end
        else if (take)
        begin
            chk = 1'b1;
            case (req_in.op)
                SLC_OP_PUSH:
                begin
                    mem_d = '{valid: 1'b1, write: 1'b1, addr: sp_q, wdata: req_in.data};
                    sp_d  = 16'(sp_q + `SLC_WORD_STEP);
                end
                SLC_OP_POP:
                begin
                    mem_d = '{valid: 1'b1, write: 1'b0, addr: sp_dec, wdata: 16'h0000};
                    sp_d  = sp_dec;
                end
                SLC_OP_CALL, SLC_OP_EXC:
                begin
                    mem_d = '{valid: 1'b1, write: 1'b1, addr: sp_q, wdata: req_in.pc[15:0]};
                    sp_d  = 16'(sp_q + `SLC_WORD_STEP);
                    hi_d  = (req_in.op == SLC_OP_CALL)
                          ? {`SLC_MSB_ZERO, 1'b0, req_in.pc[22:16]}
                          : {req_in.status_low_byte, 1'b0, req_in.pc[22:16]};
                    state_d = SLC_PC_HI;
                end
                SLC_OP_EA:
                begin
                    mem_d = '{valid: 1'b1, write: req_in.wr, addr: req_in.ea,
                              wdata: req_in.data};
                end
                default:
                begin
                    chk = 1'b0;
                end
            endcase
        end
        // cpu write of the pointer register wins over stepping
        if (sp_wr_in)
        begin
            sp_d = sp_wdata_in;
        end
        sp_d[`SLC_ALIGN_BIT] = 1'b0;
        // overflow past limit and underflow into sfr space
        trap_d = chk && ((lim_set_q && (mem_d.addr > lim_q))
                         || (mem_d.addr < `SLC_SFR_TOP));
        // secure ram gating by executing segment
        in_boot = boot_seg_in.en && (mem_d.addr >= boot_seg_in.lo)
                  && (mem_d.addr <= boot_seg_in.hi);
        in_sec  = secure_seg_in.en && (mem_d.addr >= secure_seg_in.lo)
                  && (mem_d.addr <= secure_seg_in.hi);
        deny_d  = mem_d.valid && ((in_boot && !exec_boot_in)
                                  || (in_sec && !exec_secure_in));
        if (deny_d)
        begin
            mem_d.valid = 1'b0;
        end
        err_d = trap_d || (err_q && !err_clr_in);
    end

    // limit register: loaded only by software, no reset value
    always_comb
    begin
        lim_d     = lim_q;
        lim_set_d = lim_set_q;
        if (limit_wr_in)
        begin
            lim_d     = limit_wdata_in;
            lim_set_d = 1'b1;
        end
        lim_d[`SLC_ALIGN_BIT] = 1'b0;
    end

    // limit storage kept out of reset
    always_ff @(posedge clk_in)
    begin
        lim_q <= lim_d;
    end

    // controlled state
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_q   <= SLC_IDLE;
            sp_q      <= `SLC_SP_RST;
            hi_q      <= 16'h0000;
            mem_q     <= '0;
            trap_q    <= 1'b0;
            err_q     <= 1'b0;
            deny_q    <= 1'b0;
            lim_set_q <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            sp_q      <= sp_d;
            hi_q      <= hi_d;
            mem_q     <= mem_d;
            trap_q    <= trap_d;
            err_q     <= err_d;
            deny_q    <= deny_d;
            lim_set_q <= lim_set_d;
        end
    end

    assign busy_out       = (state_q == SLC_PC_HI);
    assign mem_out        = mem_q;
    assign sp_out         = sp_q;
    assign stack_trap_out = trap_q;
    assign stack_err_out  = err_q;
    assign deny_out       = deny_q;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sp_align_a: assert property (sp_q[0] == 1'b0)
        else $error("stack pointer not word aligned");
    push_post_a: assert property (take && req_in.op == SLC_OP_PUSH && !sp_wr_in
        |=> mem_q.addr == $past(sp_q) && sp_q == $past(sp_q) + 16'h0002)
        else $error("push did not post-increment");
    pop_pre_a: assert property (take && req_in.op == SLC_OP_POP && !sp_wr_in
        |=> mem_q.addr == $past(sp_q) - 16'h0002 && sp_q == mem_q.addr)
        else $error("pop did not pre-decrement");
    call_msb_a: assert property (take && req_in.op == SLC_OP_CALL && !deny_d
        |=> ##1 mem_q.write && mem_q.wdata[15:8] == 8'h00)
        else $error("call push top byte not clear");
    exc_msb_a: assert property (take && req_in.op == SLC_OP_EXC
        |=> ##1 mem_q.wdata[15:8] == $past(req_in.status_low_byte, 2))
        else $error("exception push lacks status byte");
    lim_lsb_a: assert property (lim_set_q |-> lim_q[0] == 1'b0)
        else $error("limit bit 0 not zero");
    limit_eq_a: assert property (take && req_in.op == SLC_OP_PUSH && lim_set_q
        && sp_q == lim_q && sp_q >= 16'h0800 |=> !trap_q)
        else $error("push at limit trapped");
    limit_over_a: assert property (take && req_in.op == SLC_OP_PUSH && lim_set_q
        && sp_q > lim_q |=> trap_q)
        else $error("push past limit missed");
    under_trap_a: assert property (take && req_in.op == SLC_OP_POP && !sp_wr_in
        && sp_q < 16'h0802 |=> trap_q)
        else $error("underflow missed");
    err_sticky_a: assert property (err_q && !err_clr_in && !trap_d |=> err_q)
        else $error("sticky flag lost");
    trap_flag_a: assert property (trap_q |-> err_q)
        else $error("trap without sticky flag");
    deny_gate_a: assert property (deny_q |-> !mem_q.valid)
        else $error("denied access issued");

    cv_over_c: cover property (take && req_in.op == SLC_OP_PUSH ##1 trap_q);
    cv_under_c: cover property (take && req_in.op == SLC_OP_POP ##1 trap_q);
    cv_exc_c: cover property (take && req_in.op == SLC_OP_EXC ##1 busy_out ##1 mem_q.valid);
    cv_deny_c: cover property (deny_q);
endmodule

// File: slc_regs.svh
// constants for the stack limit checker: reset values, boundaries, steps
// assumes a 16-bit byte-addressed data space with word-aligned stack
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH
`define SLC_SP_RST    16'h0800
`define SLC_SFR_TOP   16'h0800
`define SLC_WORD_STEP 16'h0002
`define SLC_ALIGN_BIT 0
`define SLC_MSB_ZERO  8'h00
`endif

// File: slc_pkg.sv
// types for the stack limit checker
// assumes one core clock shared with the cpu address generation logic
package slc_pkg;
    typedef enum logic [2:0] {
        SLC_OP_NONE, SLC_OP_PUSH, SLC_OP_POP, SLC_OP_CALL, SLC_OP_EXC, SLC_OP_EA
    } slc_op_t;
    typedef enum logic {SLC_IDLE, SLC_PC_HI} slc_state_t;
    typedef struct packed {
        slc_op_t     op;
        logic        wr;
        logic [15:0] data;
        logic [22:0] pc;
        logic [7:0]  status_low_byte;
        logic [15:0] ea;
    } slc_req_t;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } slc_mem_t;
    typedef struct packed {
        logic        en;
        logic [15:0] lo;
        logic [15:0] hi;
    } slc_seg_t;
endpackage

// File: slc_cpu_model.sv
// cpu side model: issues stack requests and counts trap pulses
// assumes the checker takes a request only while busy_in is low
`timescale 1ns/1ns

module slc_cpu_model
    import slc_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic busy_in,
    input  wire logic trap_in,
    output logic      req_valid_out,
    output slc_req_t  req_out,
    output int        traps_out
);
    initial
    begin
        req_valid_out = 1'b0;
        req_out       = '0;
    end

    // exception logic counts every clock edge on which trap_in is high
    always @(posedge clk_in)
        if (trap_in === 1'b1)
            traps_out <= traps_out + 1;

    // hold the request one edge, then scramble the released lines
    task automatic send(input slc_req_t r);
        @(posedge clk_in);
        while (busy_in === 1'b1)
            @(posedge clk_in);
        req_valid_out <= 1'b1;
        req_out       <= r;
        @(posedge clk_in);
        req_valid_out <= 1'b0;
        req_out       <= ~r;
    endtask
endmodule

// File: testbench.sv
// self-checking bench for the stack limit checker
// assumes the cpu model drives requests; bench drives the side inputs
`timescale 1ns/1ns

module testbench
    import slc_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, sp_wr = 1'b0, lim_wr = 1'b0;
    logic ex_boot = 1'b0, ex_sec = 1'b0, clr = 1'b0, rv, busy, trap, err, deny;
    logic [15:0] sp_wd = '0, lim_wd = '0, sp;
    slc_seg_t    bseg = '0, sseg = '0;
    slc_req_t    rq;
    slc_mem_t    mem;
    int          traps, n_errors = 0, n_checks = 0, cycles = 0;

    always #20 clk = ~clk;

    slc_cpu_model i_slc_cpu_model (.clk_in(clk), .busy_in(busy), .trap_in(trap),
        .req_valid_out(rv), .req_out(rq), .traps_out(traps));
    slc_stack_limit_checker i_slc_stack_limit_checker (.clk_in(clk), .rst_n_in(rst_n),
        .req_valid_in(rv), .req_in(rq), .busy_out(busy), .sp_wr_in(sp_wr),
        .sp_wdata_in(sp_wd), .limit_wr_in(lim_wr), .limit_wdata_in(lim_wd),
        .boot_seg_in(bseg), .secure_seg_in(sseg), .exec_boot_in(ex_boot),
        .exec_secure_in(ex_sec), .err_clr_in(clr), .mem_out(mem), .sp_out(sp),
        .stack_trap_out(trap), .stack_err_out(err), .deny_out(deny));

    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one request, then let the answering edge settle
    task automatic run(input slc_op_t op, input logic [15:0] d, input logic [22:0] pc,
                       input logic [7:0] status_low_byte);
        i_slc_cpu_model.send('{op, 1'b0, d, pc, status_low_byte, d});
        #1;
    endtask

    task automatic side(input logic s, input logic [15:0] v);
        @(posedge clk);
        sp_wr  <= s;
        lim_wr <= !s;
        sp_wd  <= v;
        lim_wd <= v;
        @(posedge clk);
        sp_wr  <= 1'b0;
        lim_wr <= 1'b0;
        repeat (2) @(posedge clk); // no stack read right after a limit write
    endtask

    task automatic t_stack;
        chk("sp_rst", sp, 16'h0800);
        chk("idle", {busy, trap, err, deny, mem.valid}, 5'h0);
        run(SLC_OP_PUSH, 16'h1234, '0, '0);
        chk("push", mem, {2'b11, 16'h0800, 16'h1234});
        chk("push_sp", {sp, trap}, {16'h0802, 1'b0});
        run(SLC_OP_POP, '0, '0, '0);
        chk("pop", {mem.valid, mem.write, mem.addr, sp}, {2'b10, 32'h08000800});
    endtask

    task automatic t_pc;
        run(SLC_OP_CALL, '0, 23'h7abcde, 8'ha5);
        chk("call_lo", {mem, busy}, {2'b11, 16'h0800, 16'hbcde, 1'b1});
        @(posedge clk);
        #1;
        chk("call_hi", {mem, sp}, {2'b11, 16'h0802, 16'h007a, 16'h0804});
        run(SLC_OP_EXC, '0, 23'h12abcd, 8'ha5);
        @(posedge clk);
        #1;
        chk("exc_hi", {mem.addr, mem.wdata}, {16'h0806, 16'ha512});
    endtask

    task automatic t_limit;
        int t0;
        side(1'b0, 16'h0a05);
        side(1'b1, 16'h0a04);
        t0 = traps;
        run(SLC_OP_PUSH, 16'h5555, '0, '0);
        chk("at_limit", trap, 1'b0);
        run(SLC_OP_PUSH, 16'h5555, '0, '0);
        chk("over", {trap, err}, 2'b11);
        @(posedge clk);
        #1;
        chk("pulse", {trap, err, traps - t0}, {2'b01, 32'd1});
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
        #1;
        chk("clear", err, 1'b0);
        run(SLC_OP_EA, 16'h0a05, '0, '0);
        chk("ea_over", trap, 1'b1);
        run(SLC_OP_EA, 16'h0a04, '0, '0);
        chk("ea_ok", trap, 1'b0);
        side(1'b1, 16'h0800);
        run(SLC_OP_POP, '0, '0, '0);
        chk("under", {mem.addr, trap}, {16'h07fe, 1'b1});
    endtask

    task automatic t_secure;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            bseg    <= '{i < 2, 16'h0900, 16'h09ff};
            sseg    <= '{i >= 2, 16'h0900, 16'h09ff};
            ex_boot <= i == 1;
            ex_sec  <= i == 3;
            run(SLC_OP_EA, 16'h0910, '0, '0);
            chk("gate", {deny, mem.valid}, {!i[0], i[0]});
        end
    endtask

    // mid-run reset: pointer and flags return, stale limit stays unarmed
    task automatic t_reset;
        chk("err_set", err, 1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("rst", {sp, busy, trap, err, deny, mem.valid}, {16'h0800, 5'h00});
        side(1'b1, 16'h0b00);
        run(SLC_OP_PUSH, 16'h0a0a, '0, '0);
        chk("rst_push", {mem.addr, trap}, {16'h0b00, 1'b0});
        i_slc_cpu_model.send('{SLC_OP_EA, 1'b1, 16'hbeef, 23'h000000, 8'h00, 16'h0c00});
        #1;
        chk("ea_wr", {mem, trap}, {2'b11, 16'h0c00, 16'hbeef, 1'b0});
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            conclude();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        t_stack();
        t_pc();
        t_limit();
        t_secure();
        t_reset();
        conclude();
    end
endmodule
